// ### sic_top.v
// Front-panel status, fault, signal-strength and set-button logic
// Operation
// - Supply indicator lit only when supply good; the lamp test here also lights it
// - Activity: off idle, flash config, steady cyclic
// - Fault: off, fast link-loss flash, steady bus error
// - Wire mode faults give slow flash
// - Controller mode faults give slow flash
// - Bar graph shows strength per data rate
// - Update or stick write runs chase sequence
// - Excessive signal flashes the bar graph
// - Transmit indicator follows serial transmit activity
// - Receive indicator follows serial receive activity
// - One-second hold applies; flash then steady
// - Confirmed station change accepted without power cycle
// - Strength value readable by external controller
// - Point-to-point: both ends show same level
// - Master in network lights yellow only
// - Remote shows strength of direct neighbour
//
// Notes for integrators
// - Every panel output is a flop, so each lamp lags its source by one cycle.
// - The flash divider free-runs from reset; a lamp that starts flashing
//   picks up mid-phase, so its first on or off time may be short.
// - The slow flash is derived from the fast one, so the two never drift.
// - Signal strength arrives as a magnitude: a smaller number is a stronger
//   signal, and the thresholds move by one step per data-rate code.
// - Rate codes above the fastest are clamped, not rejected.
// - The button counter stops once the hold time is reached, so a long press
//   still gives exactly one apply pulse; releasing the button re-arms it.
// - Interrupt status bits are sticky and write-one-to-clear; an event in
//   the same cycle as its clear keeps the bit set, so no event is lost.
// - Lamp test overrides every lamp, including a disabled bar graph.
// - Reads of unmapped offsets return zero; writes to them are ignored.
//
// Design decisions made here: the strobed register port and the register offsets.
`include "sic_defines.vh"

module sic_top #(
    // Half period of the fast flash in clock cycles
    parameter FAST_HALF = `SIC_CLK_HZ * 10 / (2 * `SIC_FAST_HZ_X10),
    // Button hold time in clock cycles
    parameter HOLD_CYC = `SIC_CLK_HZ / 1000 * `SIC_HOLD_MS
) (
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [31:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rd_data_o,
    // Status sources
    input wire supply_good_i,
    input wire comm_config_i,
    input wire comm_cyclic_i,
    input wire link_lost_i,
    input wire local_bus_err_i,
    input wire ctrl_mode_i,
    input wire dup_map_i,
    input wire miss_in_i,
    input wire miss_out_i,
    input wire addr_changed_i,
    input wire no_proto_i,
    input wire rssi_valid_i,
    input wire [7:0] rssi_i,
    input wire [2:0] data_rate_i,
    input wire fw_update_i,
    input wire stick_write_i,
    input wire too_close_i,
    input wire is_master_i,
    input wire multi_remote_i,
    input wire tx_active_i,
    input wire rx_active_i,
    input wire readin_done_i,
    // Operator side
    input wire set_button_i,
    output reg supply_indicator_o,
    output reg bus_activity_indicator_o,
    output reg fault_o,
    output reg [3:0] bar_o,
    output reg tx_o,
    output reg rx_o,
    // Towards the station logic
    output reg apply_o,
    output reg irq_o
);

    // One shared divider feeds every flashing lamp. Sharing it costs a
    // little freedom of phase but keeps all lamps flashing in step,
    // which reads better on a crowded panel.
    // Flash divider: fast phase toggles each half period, slow is half of it
    reg [31:0] div_cnt;
    reg fast_ph;
    reg slow_ph;
    wire div_end = (div_cnt == FAST_HALF - 1);

    // Divide the clock for both flash rates with equal on and off time
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 32'h0;
            fast_ph <= 1'b0;
            slow_ph <= 1'b0;
        end else if (div_end) begin
            div_cnt <= 32'h0;
            fast_ph <= ~fast_ph;
            // Slow phase flips on every second fast toggle: exactly half rate
            if (fast_ph) begin
                slow_ph <= ~slow_ph;
            end
        end else begin
            div_cnt <= div_cnt + 32'h1;
        end
    end

    // The button is taken as already debounced and synchronous. A bounce
    // shorter than the hold time only restarts the count, so it can delay
    // an apply but never produce a second one.
    // Set button hold detector and read-in tracking
    reg [31:0] hold_cnt;
    reg held;
    reg readin;
    reg readin_shown;
    reg [1:0] comm_prev;
    wire [1:0] comm_now = {comm_cyclic_i, comm_config_i};

    // A press counts once when the hold reaches one second
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_cnt <= 32'h0;
            held <= 1'b0;
            apply_o <= 1'b0;
            readin <= 1'b0;
            readin_shown <= 1'b0;
            comm_prev <= 2'h0;
        end else begin
            comm_prev <= comm_now;
            apply_o <= 1'b0;
            if (!set_button_i) begin
                hold_cnt <= 32'h0;
                held <= 1'b0;
            end else if (!held) begin
                if (hold_cnt == HOLD_CYC - 1) begin
                    // Station change taken live, no power cycle needed
                    held <= 1'b1;
                    apply_o <= 1'b1;
                    readin <= 1'b1;
                    readin_shown <= 1'b0;
                end else begin
                    hold_cnt <= hold_cnt + 32'h1;
                end
            end
            if (readin && readin_done_i) begin
                // Read-in finished: steady until communication state moves
                readin <= 1'b0;
                readin_shown <= 1'b1;
            end else if (readin_shown && comm_now != comm_prev) begin
                readin_shown <= 1'b0;
            end
        end
    end

    // Faster rates need a stronger signal for the same margin, so every
    // threshold drops by one step per rate code. The low level has no
    // lower bound: any valid signal lights at least the yellow segment.
    // Signal strength level from thresholds that shift with the data rate
    wire [2:0] rate = (data_rate_i > `SIC_RATE_MAX) ? `SIC_RATE_MAX : data_rate_i;
    wire [7:0] rate_off = {5'h0, rate} * `SIC_THR_RATE_STEP;
    wire [7:0] thr_max = `SIC_THR_MAX_BASE - rate_off;
    wire [7:0] thr_vgood = thr_max + `SIC_THR_LEVEL_GAP;
    wire [7:0] thr_good = thr_vgood + `SIC_THR_LEVEL_GAP;
    reg [3:0] level_bar;

    // Magnitude in dBm: smaller means stronger signal
    always @* begin
        if (!rssi_valid_i) begin
            level_bar = 4'h0;
        end else if (rssi_i <= thr_max) begin
            level_bar = 4'hF;
        end else if (rssi_i <= thr_vgood) begin
            level_bar = 4'h7;
        end else if (rssi_i <= thr_good) begin
            level_bar = 4'h3;
        end else begin
            level_bar = 4'h1;
        end
    end

    // The chase restarts at the bottom segment each time it is requested,
    // so the operator always sees the sweep begin from the yellow lamp.
    // Chase sequence position, stepped on fast divider ends
    reg [1:0] chase_pos;
    wire chase_on = fw_update_i | stick_write_i;

    // Walk one segment at a time from the bottom to the top
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chase_pos <= 2'h0;
        end else if (!chase_on) begin
            chase_pos <= 2'h0;
        end else if (div_end) begin
            chase_pos <= chase_pos + 2'h1;
        end
    end

    // Events are rising edges of their sources, so a fault that stays
    // present raises one interrupt, not one per cycle. Software must
    // clear the bit to hear about the next occurrence.
    // Register state
    reg [1:0] ctrl;
    reg [`SIC_IRQ_W-1:0] irq_stat;
    reg [`SIC_IRQ_W-1:0] irq_mask;
    reg link_prev;
    reg err_prev;
    reg close_prev;
    wire [`SIC_IRQ_W-1:0] irq_evt = {too_close_i & ~close_prev, apply_o,
                                     local_bus_err_i & ~err_prev, link_lost_i & ~link_prev};
    wire wr_stat = wr_i && addr_i == `SIC_REG_IRQ_STAT;
    wire [`SIC_IRQ_W-1:0] w1c = wr_stat ? wr_data_i[`SIC_IRQ_W-1:0] : {`SIC_IRQ_W{1'b0}};

    // Control, mask and sticky status; a new event beats its own clear
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl <= `SIC_CTRL_RST;
            irq_mask <= `SIC_IRQ_MASK_RST;
            irq_stat <= {`SIC_IRQ_W{1'b0}};
            link_prev <= 1'b0;
            err_prev <= 1'b0;
            close_prev <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            link_prev <= link_lost_i;
            err_prev <= local_bus_err_i;
            close_prev <= too_close_i;
            if (wr_i && addr_i == `SIC_REG_CTRL) begin
                ctrl <= wr_data_i[1:0];
            end
            if (wr_i && addr_i == `SIC_REG_IRQ_MASK) begin
                irq_mask <= wr_data_i[`SIC_IRQ_W-1:0];
            end
            irq_stat <= (irq_stat & ~w1c) | irq_evt;
            irq_o <= |(((irq_stat & ~w1c) | irq_evt) & irq_mask);
        end
    end

    // Returning zero outside the read cycle keeps a shared read bus clean
    // when several blocks are ORed together upstream.
    // Read data stands one cycle after the strobe, zero otherwise
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                `SIC_REG_CTRL: rd_data_o <= {30'h0, ctrl};
                `SIC_REG_STATUS: rd_data_o <= {22'h0, tx_o, rx_o, bar_o, fault_o,
                                               bus_activity_indicator_o, supply_indicator_o,
                                               readin};
                `SIC_REG_IRQ_STAT: rd_data_o <= {28'h0, irq_stat};
                `SIC_REG_IRQ_MASK: rd_data_o <= {28'h0, irq_mask};
                // Strength for the external controller's read commands
                `SIC_REG_RSSI: rd_data_o <= {23'h0, rssi_valid_i, rssi_i};
                default: rd_data_o <= 32'h0;
            endcase
        end else begin
            rd_data_o <= 32'h0;
        end
    end

    // The mode input picks which conditions count as configuration faults;
    // a condition that does not apply in the current mode is ignored, even
    // though its input may still be driven by the station logic.
    // Fault sources in slow-flash class depend on the operating mode
    wire slow_wire = dup_map_i | miss_in_i | miss_out_i | addr_changed_i;
    wire slow_ctrl = dup_map_i | addr_changed_i | no_proto_i;
    wire slow_fault = ctrl_mode_i ? slow_ctrl : slow_wire;
    reg next_fault;
    reg next_activity;
    reg [3:0] next_bar;

    // Indicator selection with fixed priorities
    always @* begin
        // Fault: steady bus error, then fast flash, then slow flash
        if (local_bus_err_i) begin
            next_fault = 1'b1;
        end else if (link_lost_i) begin
            next_fault = fast_ph;
        end else if (slow_fault) begin
            next_fault = slow_ph;
        end else begin
            next_fault = 1'b0;
        end
        // Read-in display takes over the activity indicator
        if (readin) begin
            next_activity = slow_ph;
        end else if (readin_shown || comm_cyclic_i) begin
            next_activity = 1'b1;
        end else if (comm_config_i) begin
            next_activity = slow_ph;
        end else begin
            next_activity = 1'b0;
        end
        // Bar graph: chase, then flash, then network master, then level
        if (chase_on) begin
            next_bar = 4'h1 << chase_pos;
        end else if (too_close_i) begin
            next_bar = fast_ph ? 4'hF : 4'h0;
        end else if (is_master_i && multi_remote_i) begin
            next_bar = 4'h1;
        end else begin
            // The level source is the direct neighbour on either end
            next_bar = level_bar;
        end
        if (!ctrl[`SIC_CTRL_BAR_EN]) begin
            next_bar = 4'h0;
        end
    end

    // Registering every lamp costs one cycle of latency, invisible to the
    // eye, and keeps glitches from the selection logic off the pins.
    // The serial activity lamps are not stretched: a very short burst may
    // light them for only a few cycles.
    // All panel outputs come from flops; lamp test lights everything
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            supply_indicator_o <= 1'b0;
            bus_activity_indicator_o <= 1'b0;
            fault_o <= 1'b0;
            bar_o <= 4'h0;
            tx_o <= 1'b0;
            rx_o <= 1'b0;
        end else if (ctrl[`SIC_CTRL_LAMP_TEST]) begin
            supply_indicator_o <= 1'b1;
            bus_activity_indicator_o <= 1'b1;
            fault_o <= 1'b1;
            bar_o <= 4'hF;
            tx_o <= 1'b1;
            rx_o <= 1'b1;
        end else begin
            supply_indicator_o <= supply_good_i;
            bus_activity_indicator_o <= next_activity;
            fault_o <= next_fault;
            bar_o <= next_bar;
            tx_o <= tx_active_i;
            rx_o <= rx_active_i;
        end
    end

endmodule // sic_top

// ### sic_defines.vh
// Constants for the front-panel status indicator block
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH

// Register offsets (byte addresses)
`define SIC_REG_CTRL 8'h00
`define SIC_REG_STATUS 8'h04
`define SIC_REG_IRQ_STAT 8'h08
`define SIC_REG_IRQ_MASK 8'h0C
`define SIC_REG_RSSI 8'h10

// Control register fields and reset value
`define SIC_CTRL_BAR_EN 0
`define SIC_CTRL_LAMP_TEST 1
`define SIC_CTRL_RST 2'h1

// Interrupt status bits
`define SIC_IRQ_LINK_LOST 0
`define SIC_IRQ_BUS_ERR 1
`define SIC_IRQ_APPLY 2
`define SIC_IRQ_TOO_CLOSE 3
`define SIC_IRQ_W 4
`define SIC_IRQ_MASK_RST 4'h0

// Timing
`define SIC_CLK_HZ 125000000
`define SIC_FAST_HZ_X10 28
`define SIC_HOLD_MS 1000

// Signal strength thresholds, dBm magnitude at the slowest rate
`define SIC_THR_MAX_BASE 8'h5A
`define SIC_THR_RATE_STEP 8'h05
`define SIC_THR_LEVEL_GAP 8'h0A
`define SIC_RATE_MAX 3'h4

`endif

// ### sic_top_assertions.sv
// Port-level checker for the status indicator block
`include "sic_defines.vh"
module sic_chk #(parameter FAST_HALF = 4, parameter HOLD_CYC = 8) (
    // Clock, reset and register port
    input wire clock_i, rst_n_i, wr_i, rd_i,
    input wire [7:0] addr_i,
    input wire [31:0] wr_data_i, rd_data_o,
    // Status sources and button
    input wire supply_good_i, tx_active_i, rx_active_i, local_bus_err_i,
    input wire fw_update_i, stick_write_i, set_button_i,
    // Indicators and events
    input wire supply_indicator_o, tx_o, rx_o, fault_o, apply_o, irq_o,
    input wire [3:0] bar_o
);
    reg [1:0] ctl; // Shadow of bar enable and lamp test
    reg [31:0] hcnt; // Consecutive held-button samples
    wire [1:0] ctl_n = (wr_i && addr_i == `SIC_REG_CTRL) ? wr_data_i[1:0] : ctl;
    // Lamp test lights everything, so LED checks are gated by this shadow
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl <= `SIC_CTRL_RST;
            hcnt <= 32'h0;
        end else begin
            ctl <= ctl_n;
            hcnt <= set_button_i ? hcnt + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_mask_off;
        wr_i && addr_i == `SIC_REG_IRQ_MASK && wr_data_i[3:0] == 4'h0 ##1 !wr_i;
    endsequence
    a_supply_track:
        assert property (!ctl_n[1] |=> supply_indicator_o == $past(supply_good_i))
        else $error("supply indicator wrong");
    a_tx_track:
        assert property (!ctl_n[1] |=> tx_o == $past(tx_active_i)) else $error("tx wrong");
    a_rx_track:
        assert property (!ctl_n[1] |=> rx_o == $past(rx_active_i)) else $error("rx wrong");
    a_fault_steady:
        assert property (local_bus_err_i |=> fault_o) else $error("bus error not steady");
    a_apply_hold:
        assert property (hcnt == HOLD_CYC |-> apply_o) else $error("apply missing");
    a_apply_only:
        assert property (apply_o |-> hcnt == HOLD_CYC) else $error("apply stray");
    a_read_window:
        assert property (rd_data_o != 32'h0 |-> $past(rd_i)) else $error("read data stray");
    a_mask_quiet:
        assert property (s_mask_off |-> ##1 !irq_o) else $error("masked irq high");
    a_chase_onehot:
        assert property ((fw_update_i || stick_write_i) && ctl_n == 2'h1 |=> $onehot(bar_o))
        else $error("chase not one-hot");
endmodule // sic_chk
bind sic_top sic_chk #(.FAST_HALF(FAST_HALF), .HOLD_CYC(HOLD_CYC)) u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .supply_good_i(supply_good_i),
    .tx_active_i(tx_active_i), .rx_active_i(rx_active_i), .local_bus_err_i(local_bus_err_i),
    .fw_update_i(fw_update_i), .stick_write_i(stick_write_i), .set_button_i(set_button_i),
    .supply_indicator_o(supply_indicator_o), .tx_o(tx_o), .rx_o(rx_o), .fault_o(fault_o),
    .apply_o(apply_o), .irq_o(irq_o), .bar_o(bar_o));

// ### sic_operator.sv
// Operator model holding the set button for a commanded time
module sic_operator (
    input wire clock_i,
    input wire go_i,
    input wire [7:0] len_i,
    output reg set_button_o
);
    reg [7:0] left = 8'h00; // Press cycles still to go
    initial set_button_o = 1'b0;
    // A press lasts len_i cycles; a short one lets us probe the refusal
    always @(posedge clock_i) begin
        if (go_i) left <= len_i;
        else if (left != 8'h00) left <= left - 8'h01;
        set_button_o <= go_i ? (len_i != 8'h00) : (left > 8'h01);
    end
endmodule // sic_operator

// ### status_indicator_control_tb_top.sv
// Self-checking bench for the status indicator block
`include "sic_defines.vh"
module status_indicator_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 0, rst_n_i = 0, wr = 0, rd = 0, go = 0, cm = 0, sup = 0, cfg = 0;
    logic cyc = 0, tx = 0, rx = 0, done = 0, rv = 0, fw = 0, stk = 0, cls = 0, mst = 0, mlt = 0;
    logic [6:0] flt = 0; // Link, bus, map, in, out, address, protocol
    logic [7:0] adr = 0, len = 0, rssi = 0;
    logic [2:0] rate = 0;
    logic [31:0] wd = 0;
    logic [1:0] sel = 0; // Output watched by meas
    wire btn, sio, bao, flo, txo, rxo, apo, irq;
    wire [3:0] bar;
    wire [31:0] rdd;
    int errors = 0, checks = 0, hi, tg, napply = 0;
    int off[7] = '{0, 1, 10, 11, 20, 21, 60};
    logic [3:0] lvl[7] = '{4'hF, 4'h7, 4'h7, 4'h3, 4'h3, 4'h1, 4'h1};
    wire mon = sel == 0 ? flo : sel == 1 ? bao : sel == 2 ? bar == 4'hF : bar == 4'h1;
    sic_top #(.FAST_HALF(4), .HOLD_CYC(8)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(adr), .wr_data_i(wd), .wr_i(wr),
        .rd_i(rd), .rd_data_o(rdd), .supply_good_i(sup), .comm_config_i(cfg),
        .comm_cyclic_i(cyc), .link_lost_i(flt[0]), .local_bus_err_i(flt[1]),
        .ctrl_mode_i(cm), .dup_map_i(flt[2]), .miss_in_i(flt[3]), .miss_out_i(flt[4]),
        .addr_changed_i(flt[5]), .no_proto_i(flt[6]), .rssi_valid_i(rv), .rssi_i(rssi),
        .data_rate_i(rate), .fw_update_i(fw), .stick_write_i(stk), .too_close_i(cls),
        .is_master_i(mst), .multi_remote_i(mlt), .tx_active_i(tx), .rx_active_i(rx),
        .readin_done_i(done), .set_button_i(btn), .supply_indicator_o(sio),
        .bus_activity_indicator_o(bao), .fault_o(flo), .bar_o(bar), .tx_o(txo),
        .rx_o(rxo), .apply_o(apo), .irq_o(irq));
    sic_operator op (.clock_i(clock_i), .go_i(go), .len_i(len), .set_button_o(btn));
    initial forever #4 clock_i = ~clock_i;
    always @(posedge clock_i) napply <= napply + apo; // Counts apply pulses
    task chk(input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task tick(input int n); repeat (n) @(posedge clock_i); endtask
    task wrr(input [7:0] a, input [31:0] d);
        adr <= a; wd <= d; wr <= 1; tick(1); wr <= 0; tick(1);
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        adr <= a; rd <= 1; tick(1); rd <= 0; #1 chk(rdd, e); tick(1);
    endtask
    task press(input [7:0] n); len <= n; go <= 1; tick(1); go <= 0; tick(20); endtask
    // Highs and toggles over 32 cycles; 32 is a whole number of flash periods
    task meas(input logic [1:0] s);
        logic p;
        sel = s; hi = 0; tg = 0;
        tick(1); #1 p = mon;
        repeat (32) begin
            tick(1); #1 hi += mon; tg += (mon != p); p = mon;
        end
        tick(1);
    endtask
    task t_button;
        wrr(`SIC_REG_IRQ_MASK, 32'h4);
        press(8'h07); chk(napply, 0);
        press(8'h0C); chk(napply, 1);
        chk(irq, 1);
        meas(1); chk(hi, 16);
        done <= 1; tick(1); done <= 0; meas(1); chk(hi, 32);
        rdc(`SIC_REG_IRQ_STAT, 32'h4);
        wrr(`SIC_REG_IRQ_MASK, 32'h0); tick(1); chk(irq, 0);
        wrr(`SIC_REG_IRQ_MASK, 32'h4); tick(1); chk(irq, 1);
        wrr(`SIC_REG_IRQ_STAT, 32'h4); tick(1); chk(irq, 0);
    endtask
    task t_leds;
        for (int i = 0; i < 8; i++) begin
            {sup, tx, rx} <= 3'(i); tick(2);
            chk({sio, txo, rxo}, i);
        end
        cfg <= 1; meas(1); chk(hi, 16);
        cfg <= 0; cyc <= 1; meas(1); chk(hi, 32);
        cyc <= 0; meas(1); chk(hi, 0);
    endtask
    task t_fault;
        for (int m = 0; m < 2; m++)
            for (int b = 2; b < 7; b++) begin
                cm <= m[0]; flt <= 7'(1 << b); meas(0);
                chk(hi, (m ? (b != 3 && b != 4) : (b != 6)) ? 16 : 0);
                chk(tg < 5, 1);
            end
        flt <= 7'h05; meas(0); chk(hi, 16);
        chk(tg > 6, 1);
        flt <= 7'h07; meas(0); chk(hi, 32);
        flt <= 7'h00; meas(0); chk(hi, 0);
    endtask
    task t_bar;
        rv <= 1;
        for (int r = 0; r < 6; r++)
            for (int k = 0; k < 7; k++) begin
                rate <= 3'(r); rssi <= 8'(90 - 5 * (r > 4 ? 4 : r) + off[k]);
                tick(2); chk(bar, lvl[k]);
            end
        rdc(`SIC_REG_RSSI, {23'h0, 1'b1, rssi});
        rssi <= 8'h46; mst <= 1; mlt <= 1; tick(2); chk(bar, 4'h1);
        mlt <= 0; tick(2); chk(bar, 4'hF);
        cls <= 1; meas(2); chk(hi, 16);
        cls <= 0;
        for (int c = 1; c < 3; c++) begin
            // Let the first, possibly short, chase step pass before measuring
            {fw, stk} <= 2'(c); tick(16); meas(3); chk(hi, 8);
        end
        {fw, stk} <= 2'h0; rv <= 0; tick(2); chk(bar, 4'h0);
        wrr(`SIC_REG_CTRL, 32'h3); tick(1); chk({sio, bao, flo, bar, txo, rxo}, 9'h1FF);
        wrr(`SIC_REG_CTRL, 32'h0); tick(1); chk(bar, 4'h0);
        // Supply, rx and tx inputs still high from the LED scenario; bar disabled
        rdc(`SIC_REG_STATUS, 32'h302);
        // Link-lost, bus-error and too-close rises are all still latched
        rdc(`SIC_REG_IRQ_STAT, 32'hB);
        chk(irq, 0);
    endtask
    task conclude;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Main sequence: reset, registers, then each behaviour
    initial begin
        tick(5);
        rst_n_i <= 1;
        rdc(`SIC_REG_CTRL, 32'h1);
        rdc(8'h20, 32'h0);
        t_button;
        t_leds;
        t_fault;
        t_bar;
        conclude;
    end
    // Watchdog well past the thousand or so cycles the run needs
    initial begin
        #100us;
        errors++;
        conclude;
    end
endmodule // status_indicator_control_tb_top
